// ### rtl/fault_status_pkg.sv
package fault_status_pkg;

   localparam int CLK_HZ          = 50_000_000;
   localparam int OSC_HZ          = 4_000_000;
   localparam logic [5:0] TICK_STEP = 6'(OSC_HZ / 1_000_000);
   localparam logic [5:0] TICK_MOD  = 6'(CLK_HZ / 1_000_000);

   localparam int GROUND_FAULT_NS = 4_096_000;
   localparam int GROUND_STEPS    = (GROUND_FAULT_NS / 1000) * (OSC_HZ / 1_000_000);
   localparam int GL_BITS         = $clog2(GROUND_STEPS);

   localparam int HOLD_LONG_US    = 1000;
   localparam int HOLD_LONG_TICKS = HOLD_LONG_US * (OSC_HZ / 1_000_000);
   localparam int FRAME_TO_US     = 200;
   localparam int FRAME_TO_TICKS  = FRAME_TO_US * (OSC_HZ / 1_000_000);

   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_FLAGS  = 8'h04;
   localparam logic [7:0] REG_EVENTS = 8'h08;
   localparam logic [7:0] REG_MASK   = 8'h0c;
   localparam logic [7:0] REG_SERIAL = 8'h10;
   localparam logic [7:0] REG_TYPE   = 8'h14;

   localparam int CFG_GLE_BIT       = 0;
   localparam logic CONFIG_RESET    = 1'b0;
   localparam int SWITCH_DATA_BIT   = 6;
   localparam int EV_W              = 5;
   localparam logic [4:0] EV_RESET  = 5'h00;
   localparam logic [4:0] MASK_RESET = 5'h00;

   typedef enum logic [2:0] {
      OP_NONE       = 3'b000,
      OP_INIT       = 3'b001,
      OP_REV_INIT   = 3'b010,
      OP_ST_DISABLE = 3'b011,
      OP_ST_ENABLE  = 3'b100,
      OP_CLEAR      = 3'b101,
      OP_READ_ACCEL = 3'b110,
      OP_STATUS     = 3'b111
   } cmd_op_t;

   typedef struct packed {
      cmd_op_t    op;
      logic [7:0] data;
   } cmd_t;

   typedef struct packed {
      logic undervoltage;
      logic earth_open_flag;
      logic accel_fault;
   } fault_flags_t;

   typedef struct packed {
      logic ground_sense_pin;
      logic test_mode;
      logic hold_low;
      logic regulator_low;
      logic bus_low;
      logic fuse_fault;
      logic parity_fault;
   } pins_t;

endpackage

// ### rtl/fault_status_monitor.sv
// Operation
// - Ground-loss detection runs only while the ground-loss enable bit is one.
// - Sensed open chassis with detection enabled advances the 14-bit counter.
// - Sensed voltage below threshold counts the ground-loss counter back down.
// - Ground loss is declared only when the counter overflows.
// - Ground loss past 4.096 ms sets fault and earth flags, zeroes reads.
// - Short hold-supply dip sets undervoltage flag and zeroes reads, no reset.
// - Hold-supply dip over 1 ms holds reset, switch open, no answers.
// - Bus low beyond frame timeout holds reset, switch open, no answers.
// - Regulated supply low holds reset, switch open, no answers until recovery.
// - Fuse or parity fault sets accelerometer fault and zeroes reads.
// - Lockout arms only after two consecutive self-test disable commands.
// - Under lockout, fault flags stay latched until clear command or reset.
// - All timing derives from a nominal 4 MHz oscillator tick.
// - Regulator below minimum keeps device in reset and silent.
// - In test mode the ground-sense pin feeds trim serial data instead.
// - Identification data is readable at any time while active.
// - Bus switch opens on reset, closes on init command with bit six.
`timescale 1ns/10ps
module fault_status_monitor #(
   parameter int          GL_W        = fault_status_pkg::GL_BITS,
   parameter int          HOLD_TICKS  = fault_status_pkg::HOLD_LONG_TICKS,
   parameter int          FRAME_TICKS = fault_status_pkg::FRAME_TO_TICKS,
   parameter logic [31:0] SERIAL_ID   = 32'h0000_0001, // Arbitrary value
   parameter logic [7:0]  TYPE_ID     = 8'h00          // Arbitrary value
) (
   input  wire logic                           i_clock,
   input  wire logic                           i_rst,
   input  wire fault_status_pkg::pins_t        i_pins,
   input  wire logic                           i_cmd_valid,
   input  wire fault_status_pkg::cmd_t         i_cmd,
   input  wire logic [7:0]                     i_addr,
   input  wire logic [31:0]                    i_wdata,
   input  wire logic                           i_wr,
   input  wire logic                           i_rd,
   output logic [31:0]                         o_rdata,
   output logic                                o_irq,
   output fault_status_pkg::fault_flags_t      o_flags,
   output logic                                o_accel_zero,
   output logic                                o_bus_switch_closed,
   output logic                                o_hold_reset,
   output logic                                o_respond_en,
   output logic                                o_self_test_lockout,
   output logic                                o_trim_din
);
   import fault_status_pkg::*;

   localparam int HW = $clog2(HOLD_TICKS + 2);
   localparam int FW = $clog2(FRAME_TICKS + 2);

   if (GL_W < 2 || GL_W > 24 || HOLD_TICKS < 1 || FRAME_TICKS < 1) begin : g_check
      $error("fault_status_monitor: unsupported parameter values");
   end

   // Pin synchronisers; stage one is read only by stage two
   pins_t s1;
   pins_t s2;
   pins_t s3;
   pins_t clean;
   pins_t next_clean;

   always_comb begin
      for (int b = 0; b < $bits(pins_t); b++) begin
         next_clean[b] = (s2[b] == s3[b]) ? s3[b] : clean[b];
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         s1    <= '0;
         s2    <= '0;
         s3    <= '0;
         clean <= '0;
      end else begin
         s1    <= i_pins;
         s2    <= s1;
         s3    <= s2;
         clean <= next_clean;
      end
   end

   // Fractional divider: 50 MHz clock yields an average 4 MHz tick
   logic [5:0] tick_acc;
   logic [5:0] next_tick_acc;
   logic       tick;
   logic       next_tick;

   always_comb begin
      next_tick_acc = tick_acc + TICK_STEP;
      next_tick     = 1'b0;
      if (next_tick_acc >= TICK_MOD) begin
         next_tick_acc = next_tick_acc - TICK_MOD;
         next_tick     = 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         tick_acc <= '0;
         tick     <= 1'b0;
      end else begin
         tick_acc <= next_tick_acc;
         tick     <= next_tick;
      end
   end

   // Supply and frame timers; they run through the hold so it can release
   logic [HW-1:0] hold_cnt;
   logic [HW-1:0] next_hold_cnt;
   logic [FW-1:0] frame_cnt;
   logic [FW-1:0] next_frame_cnt;
   logic          hold;
   logic          next_hold;

   always_comb begin
      next_hold_cnt  = hold_cnt;
      next_frame_cnt = frame_cnt;
      if (!clean.hold_low) begin
         next_hold_cnt = '0;
      end else if (tick && hold_cnt <= HW'(HOLD_TICKS)) begin
         next_hold_cnt = hold_cnt + 1'b1;
      end
      if (!clean.bus_low) begin
         next_frame_cnt = '0;
      end else if (tick && frame_cnt <= FW'(FRAME_TICKS)) begin
         next_frame_cnt = frame_cnt + 1'b1;
      end
      next_hold = clean.regulator_low
                | (hold_cnt > HW'(HOLD_TICKS))
                | (frame_cnt > FW'(FRAME_TICKS));
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         hold_cnt  <= '0;
         frame_cnt <= '0;
         hold      <= 1'b0;
      end else begin
         hold_cnt  <= next_hold_cnt;
         frame_cnt <= next_frame_cnt;
         hold      <= next_hold;
      end
   end

   // Fault core; the supply hold acts as a continuous internal reset
   logic            gle;
   logic [GL_W-1:0] gl_cnt;
   logic [GL_W-1:0] next_gl_cnt;
   logic            earth;
   logic            next_earth;
   fault_flags_t    flags;
   fault_flags_t    next_flags;
   fault_flags_t    live;
   logic            lockout;
   logic            next_lockout;
   logic            prev_dis;
   logic            next_prev_dis;
   logic            sw;
   logic            next_sw;
   logic            trim;
   logic            next_trim;
   logic            zero;
   logic            next_zero;
   logic            respond;
   logic            next_respond;
   logic            cmd_ok;
   logic            clr;
   logic            dis;
   logic            ovf;

   always_comb begin
      cmd_ok        = i_cmd_valid && !hold;
      clr           = cmd_ok && i_cmd.op == OP_CLEAR;
      dis           = cmd_ok && i_cmd.op == OP_ST_DISABLE;
      ovf           = 1'b0;
      next_gl_cnt   = gl_cnt;
      next_lockout  = lockout;
      next_prev_dis = prev_dis;
      next_sw       = sw;
      next_trim     = clean.test_mode & clean.ground_sense_pin;
      if (gle && !clean.test_mode && tick) begin
         if (clean.ground_sense_pin) begin
            if (gl_cnt == '1) begin
               ovf = 1'b1;
            end else begin
               next_gl_cnt = gl_cnt + 1'b1;
            end
         end else if (gl_cnt != '0) begin
            next_gl_cnt = gl_cnt - 1'b1;
         end
      end
      next_earth = (earth & ~clr) | ovf;
      live.undervoltage    = clean.hold_low;
      live.earth_open_flag = earth;
      live.accel_fault     = earth | clean.fuse_fault | clean.parity_fault;
      if (lockout) begin
         next_flags = (flags & ~{$bits(fault_flags_t){clr}}) | live;
      end else begin
         next_flags = live;
      end
      if (cmd_ok) begin
         next_prev_dis = dis;
         if (dis && prev_dis) begin
            next_lockout = 1'b1;
         end
         if ((i_cmd.op == OP_INIT || i_cmd.op == OP_REV_INIT) && i_cmd.data[SWITCH_DATA_BIT]) begin
            next_sw = 1'b1;
         end
      end
      if (hold) begin
         next_gl_cnt   = '0;
         next_earth    = 1'b0;
         next_flags    = '0;
         next_lockout  = 1'b0;
         next_prev_dis = 1'b0;
         next_sw       = 1'b0;
      end
      next_zero = |next_flags;
      // Answers stop on the same edge as the hold rises
      next_respond = !next_hold;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         gl_cnt   <= '0;
         earth    <= 1'b0;
         flags    <= '0;
         lockout  <= 1'b0;
         prev_dis <= 1'b0;
         sw       <= 1'b0;
         trim     <= 1'b0;
         zero     <= 1'b0;
         respond  <= 1'b0;
      end else begin
         gl_cnt   <= next_gl_cnt;
         earth    <= next_earth;
         flags    <= next_flags;
         lockout  <= next_lockout;
         prev_dis <= next_prev_dis;
         sw       <= next_sw;
         trim     <= next_trim;
         zero     <= next_zero;
         respond  <= next_respond;
      end
   end

   // Register port, sticky events and interrupt
   logic [EV_W-1:0] events;
   logic [EV_W-1:0] next_events;
   logic [EV_W-1:0] mask;
   logic [EV_W-1:0] next_mask;
   logic [EV_W-1:0] ev;
   logic            next_gle;
   logic [31:0]     rdata;
   logic [31:0]     next_rdata;
   logic            irq;
   logic            next_irq;

   always_comb begin
      ev = {next_lockout & ~lockout, next_hold & ~hold,
            next_flags.accel_fault & ~flags.accel_fault,
            next_flags.undervoltage & ~flags.undervoltage,
            next_earth & ~earth};
      next_gle    = gle;
      next_mask   = mask;
      next_events = events;
      if (i_wr && i_addr == REG_CONFIG) begin
         next_gle = i_wdata[CFG_GLE_BIT];
      end
      if (i_wr && i_addr == REG_MASK) begin
         next_mask = i_wdata[EV_W-1:0];
      end
      if (i_wr && i_addr == REG_EVENTS) begin
         next_events = events & ~i_wdata[EV_W-1:0];
      end
      // Set after clear so a coincident event survives
      next_events = next_events | ev;
      next_irq    = |(next_events & next_mask);
      next_rdata  = '0;
      if (i_rd) begin
         unique case (i_addr)
            REG_CONFIG: next_rdata = {31'h0, gle};
            REG_FLAGS:  next_rdata = {26'h0, lockout, hold, sw, flags};
            REG_EVENTS: next_rdata = {27'h0, events};
            REG_MASK:   next_rdata = {27'h0, mask};
            REG_SERIAL: next_rdata = SERIAL_ID;
            REG_TYPE:   next_rdata = {24'h0, TYPE_ID};
            default:    next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         gle    <= CONFIG_RESET;
         mask   <= MASK_RESET;
         events <= EV_RESET;
         rdata  <= '0;
         irq    <= 1'b0;
      end else begin
         gle    <= next_gle;
         mask   <= next_mask;
         events <= next_events;
         rdata  <= next_rdata;
         irq    <= next_irq;
      end
   end

   assign o_rdata             = rdata;
   assign o_irq               = irq;
   assign o_flags             = flags;
   assign o_accel_zero        = zero;
   assign o_bus_switch_closed = sw;
   assign o_hold_reset        = hold;
   assign o_respond_en        = respond;
   assign o_self_test_lockout = lockout;
   assign o_trim_din          = trim;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   sequence s_disable;
      i_cmd_valid && !hold && i_cmd.op == OP_ST_DISABLE;
   endsequence

   sequence s_count_step;
      tick && gle && !clean.test_mode && !hold;
   endsequence

   a_gl_disabled_quiet: assert property (!gle && !earth && !hold |=> !earth)
      else $error("ground fault raised while detection disabled");
   a_gl_count_up: assert property (s_count_step ##0 (clean.ground_sense_pin && gl_cnt != '1)
      |=> gl_cnt == $past(gl_cnt) + 1'b1)
      else $error("ground counter did not advance");
   a_gl_count_down: assert property (s_count_step ##0 (!clean.ground_sense_pin && gl_cnt != '0)
      |=> gl_cnt == $past(gl_cnt) - 1'b1)
      else $error("ground counter did not reverse");
   a_gl_overflow_only: assert property ($rose(earth) |-> $past(gl_cnt) == '1)
      else $error("ground fault without counter overflow");
   a_fault_zero: assert property (|flags |-> zero)
      else $error("fault flags set but reads not zeroed");
   a_hold_silent: assert property (hold |-> !respond ##1 !sw)
      else $error("bus switch or responses active during hold");
   a_lockout_two: assert property ($rose(lockout) |-> $past(prev_dis) && $past(dis))
      else $error("lockout armed without two disable commands");
   a_lockout_single: assert property (!lockout && !prev_dis ##0 s_disable |=> !lockout)
      else $error("single disable command armed lockout");
   a_latch_keep: assert property (lockout && flags.accel_fault && !clr && !hold
      |=> flags.accel_fault)
      else $error("latched fault dropped under lockout");
   a_trim_route: assert property (clean.test_mode |=> trim == $past(clean.ground_sense_pin))
      else $error("trim data not routed in test mode");

   sequence s_close_cmd;
      i_cmd_valid && !hold && (i_cmd.op == OP_INIT || i_cmd.op == OP_REV_INIT);
   endsequence

   a_switch_close: assert property (s_close_cmd ##0 i_cmd.data[SWITCH_DATA_BIT] |=> sw)
      else $error("bus switch did not close on init command");
   a_switch_reason: assert property ($rose(sw) |-> $past(i_cmd_valid) && $past(i_cmd.data[SWITCH_DATA_BIT]))
      else $error("bus switch closed without data bit six");
   a_gl_floor: assert property (s_count_step ##0 (!clean.ground_sense_pin && gl_cnt == '0)
      |=> gl_cnt == '0)
      else $error("ground counter went below zero");
   a_earth_keep: assert property (earth && !clr && !hold |=> earth)
      else $error("ground fault indication dropped before clear");
   a_timeout_hold: assert property (frame_cnt > FW'(FRAME_TICKS) |=> hold)
      else $error("frame timeout did not hold the device in reset");
   a_supply_hold: assert property (clean.regulator_low |=> hold && !respond)
      else $error("regulator low did not hold the device in reset");
   a_under_flag: assert property (clean.hold_low && !hold |=> flags.undervoltage && zero)
      else $error("short supply dip did not raise the undervoltage flag");
   a_otp_fault: assert property ((clean.fuse_fault || clean.parity_fault) && !hold
      |=> flags.accel_fault && zero)
      else $error("fuse or parity fault did not raise the accelerometer flag");

endmodule

// ### dv/bus_master_model.sv
`timescale 1ns/10ps
module bus_master_model (
   input  wire logic                   i_clock,
   input  wire logic                   i_rst,
   input  wire logic                   i_go,
   input  wire fault_status_pkg::cmd_t i_req,
   output logic                        o_cmd_valid,
   output fault_status_pkg::cmd_t      o_cmd
);
   import fault_status_pkg::*;

   // Idle lines toggle so a stale command is never mistaken for a fresh one
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_cmd_valid <= 1'b0;
         o_cmd       <= '0;
      end else begin
         o_cmd_valid <= i_go;
         o_cmd       <= i_go ? i_req : ~o_cmd;
      end
   end
endmodule

// ### dv/tb.sv
`timescale 1ns/10ps
module tb;
   import fault_status_pkg::*;
   localparam logic [31:0] SERIAL_VAL = 32'h0000_1235; // Arbitrary value
   localparam logic [7:0]  TYPE_VAL   = 8'h5a;         // Arbitrary value
   logic         i_clock, i_rst, i_wr, i_rd, go, cmd_valid;
   logic [7:0]   i_addr;
   logic [31:0]  i_wdata, o_rdata;
   cmd_t         req, cmd_bus;
   pins_t        pins;
   fault_flags_t o_flags;
   logic         o_irq, o_accel_zero, o_switch, o_hold, o_resp, o_lock, o_trim;
   int           n_errors, tests_run;

   bus_master_model bus_master_model_inst (
      .i_clock(i_clock), .i_rst(i_rst), .i_go(go), .i_req(req), .o_cmd_valid(cmd_valid), .o_cmd(cmd_bus));

   // Short counts keep the run brief; the counter and timer waits below are scaled from them
   fault_status_monitor #(.GL_W(4), .HOLD_TICKS(8), .FRAME_TICKS(8), .SERIAL_ID(SERIAL_VAL), .TYPE_ID(TYPE_VAL))
   fault_status_monitor_inst (
      .i_clock(i_clock), .i_rst(i_rst), .i_pins(pins), .i_cmd_valid(cmd_valid), .i_cmd(cmd_bus),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
      .o_flags(o_flags), .o_accel_zero(o_accel_zero), .o_bus_switch_closed(o_switch),
      .o_hold_reset(o_hold), .o_respond_en(o_resp), .o_self_test_lockout(o_lock), .o_trim_din(o_trim));

   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   task automatic wrap_up;
      $display("Checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_clock);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd   <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask

   task automatic cmd(input cmd_op_t op, input logic [7:0] d);
      @(posedge i_clock);
      go  <= 1'b1;
      req <= '{op, d};
      @(posedge i_clock);
      go  <= 1'b0;
      wt(3);
   endtask

   task automatic set_pin(input int idx, input logic v);
      @(posedge i_clock);
      pins[idx] <= v;
   endtask

   initial begin
      wt(20000);
      n_errors++;
      wrap_up();
   end

   initial begin
      i_rst     = 1'b1;
      i_wr      = 1'b0;
      i_rd      = 1'b0;
      i_addr    = 8'h00;
      i_wdata   = 32'h0;
      go        = 1'b0;
      req       = '0;
      pins      = '0; // Ground sense held low as if tied to return
      n_errors  = 0;
      tests_run = 0;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      rd(REG_CONFIG, 32'h0);
      rd(REG_MASK, 32'h0);
      rd(REG_SERIAL, SERIAL_VAL);
      rd(REG_TYPE, {24'h0, TYPE_VAL});
      wr(8'h20, 32'hffff_ffff);
      rd(8'h20, 32'h0);
      rd(REG_FLAGS, 32'h0);
      chk({31'h0, o_switch}, 32'h0);
      // Open chassis with detection off
      set_pin(6, 1'b1);
      wt(400);
      chk({29'h0, o_flags}, 32'h0);
      // 16 ticks at 4 per 50 clocks is about 200 clocks
      wr(REG_CONFIG, 32'h1);
      wt(150);
      chk({31'h0, o_flags.earth_open_flag}, 32'h0);
      wt(110);
      chk({28'h0, o_flags, o_accel_zero}, 32'h7);
      set_pin(6, 1'b0);
      wt(60);
      chk({31'h0, o_flags.earth_open_flag}, 32'h1);
      rd(REG_EVENTS, 32'h5);
      wr(REG_MASK, 32'h1);
      wt(2);
      chk({31'h0, o_irq}, 32'h1);
      wr(REG_EVENTS, 32'h1);
      wt(2);
      chk({31'h0, o_irq}, 32'h0);
      rd(REG_EVENTS, 32'h4);
      wr(REG_MASK, 32'h0);
      wr(REG_EVENTS, 32'h1f);
      cmd(OP_CLEAR, 8'h00);
      chk({29'h0, o_flags}, 32'h0);
      // Up, down to the zero floor, up again: never reaches overflow
      wt(200);
      set_pin(6, 1'b1);
      wt(100);
      set_pin(6, 1'b0);
      wt(120);
      set_pin(6, 1'b1);
      wt(150);
      chk({31'h0, o_flags.earth_open_flag}, 32'h0);
      set_pin(6, 1'b0);
      wt(250);
      // Test mode turns the sense pin into trim data
      set_pin(5, 1'b1);
      set_pin(6, 1'b1);
      wt(300);
      chk({30'h0, o_flags.earth_open_flag, o_trim}, 32'h1);
      set_pin(6, 1'b0);
      wt(8);
      chk({31'h0, o_trim}, 32'h0);
      set_pin(5, 1'b0);
      wr(REG_CONFIG, 32'h0);
      // Switch closes only with data bit six
      cmd(OP_INIT, 8'hbf);
      chk({31'h0, o_switch}, 32'h0);
      cmd(OP_REV_INIT, 8'h40);
      chk({31'h0, o_switch}, 32'h1);
      // Short hold-supply dip
      set_pin(4, 1'b1);
      wt(20);
      chk({29'h0, o_flags.undervoltage, o_accel_zero, o_hold}, 32'h6);
      set_pin(4, 1'b0);
      wt(10);
      chk({28'h0, o_flags, o_hold}, 32'h0);
      // Bus low, regulator low, long hold dip: each holds reset
      for (int i = 2; i <= 4; i++) begin
         cmd(OP_INIT, 8'h40);
         set_pin(i, 1'b1);
         wt(200);
         chk({29'h0, o_hold, o_resp, o_switch}, 32'h4);
         cmd(OP_INIT, 8'h40);
         chk({31'h0, o_switch}, 32'h0);
         set_pin(i, 1'b0);
         wt(10);
         chk({30'h0, o_hold, o_resp}, 32'h1);
      end
      // Fuse and parity faults
      for (int i = 0; i <= 1; i++) begin
         set_pin(i, 1'b1);
         wt(10);
         chk({28'h0, o_flags, o_accel_zero}, 32'h3);
         set_pin(i, 1'b0);
         wt(10);
         chk({28'h0, o_flags, o_accel_zero}, 32'h0);
      end
      // Lockout needs two disables in a row
      cmd(OP_STATUS, 8'h00);
      cmd(OP_READ_ACCEL, 8'h00);
      cmd(OP_ST_DISABLE, 8'h00);
      cmd(OP_ST_ENABLE, 8'h00);
      cmd(OP_ST_DISABLE, 8'h00);
      chk({31'h0, o_lock}, 32'h0);
      cmd(OP_ST_DISABLE, 8'h00);
      chk({31'h0, o_lock}, 32'h1);
      set_pin(1, 1'b1);
      wt(10);
      set_pin(1, 1'b0);
      wt(20);
      chk({28'h0, o_flags, o_accel_zero}, 32'h3);
      cmd(OP_CLEAR, 8'h00);
      chk({28'h0, o_flags, o_accel_zero}, 32'h0);
      wrap_up();
   end
endmodule
